// >>> rtl/reset_cause_and_brownout_control.sv
// Local design decisions: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module reset_cause_and_brownout_control
	import rstcause_pkg::*;
(
	input wire logic SYS_CLK,
	input wire logic SYS_RST,
	input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire logic [1:0] BROWNOUT_CONFIG_MODE,
	input wire logic SLEEP_ACTIVE,
	input wire logic BROWNOUT_CIRCUIT_ACTIVE,
	input wire cause_events_t CAUSE_EVENTS,
	output logic BROWNOUT_RESET_ENABLE,
	output logic BANDGAP_FORCE_ON,
	output logic IRQ
);

	// ------------------------------------------------------------
	// Address decoding
	// ------------------------------------------------------------

	// Shared by the write and read paths
	function automatic reg_sel_t decode(input logic [ADDR_W-1:0] a);
		reg_sel_t s;
		s = SEL_NONE;
		unique case (a)
			OFF_BORCTL: s = SEL_BORCTL;
			OFF_FLAGS: s = SEL_FLAGS;
			OFF_EVSTAT: s = SEL_EVSTAT;
			OFF_EVMASK: s = SEL_EVMASK;
			default: s = SEL_NONE;
		endcase
		return s;
	endfunction

	// ------------------------------------------------------------
	// Bus slave
	// ------------------------------------------------------------
	logic wr_en; // One-cycle write pulse
	reg_wr_t wr; // Write address, data, strobes
	logic [ADDR_W-1:0] rd_addr; // Address being read
	logic [31:0] rd_data; // Read value for rd_addr
	reg_sel_t wr_sel;
	reg_sel_t rd_sel;
	logic wr_lane0; // Low byte lane is written

	assign wr_sel = decode(wr.addr);
	assign rd_sel = decode(rd_addr);
	assign wr_lane0 = wr_en && wr.strb[0];

	axil_reg_slave u_slave (
		.clk(SYS_CLK),
		.rst(SYS_RST),
		.awaddr(S_AXI_AWADDR),
		.awvalid(S_AXI_AWVALID),
		.awready(S_AXI_AWREADY),
		.wdata(S_AXI_WDATA),
		.wstrb(S_AXI_WSTRB),
		.wvalid(S_AXI_WVALID),
		.wready(S_AXI_WREADY),
		.bresp(S_AXI_BRESP),
		.bvalid(S_AXI_BVALID),
		.bready(S_AXI_BREADY),
		.araddr(S_AXI_ARADDR),
		.arvalid(S_AXI_ARVALID),
		.arready(S_AXI_ARREADY),
		.rdata(S_AXI_RDATA),
		.rresp(S_AXI_RRESP),
		.rvalid(S_AXI_RVALID),
		.rready(S_AXI_RREADY),
		.wr_en(wr_en),
		.wr(wr),
		.wr_err(wr_sel == SEL_NONE),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.rd_err(rd_sel == SEL_NONE)
	);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// Fuse mode, sleep and the analog ready come from other domains
	logic [1:0] mode_s1;
	logic [1:0] mode_q; // Synchronised configuration mode
	logic sleep_s1;
	logic sleep_q;
	logic rdy_s1;
	logic rdy_q; // Synchronised circuit-ready level

	// Two flops each; only the second stage is read
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			mode_s1 <= MODE_OFF;
			mode_q <= MODE_OFF;
			sleep_s1 <= 1'b0;
			sleep_q <= 1'b0;
			rdy_s1 <= 1'b0;
			rdy_q <= 1'b0;
		end else begin
			mode_s1 <= BROWNOUT_CONFIG_MODE;
			mode_q <= mode_s1;
			sleep_s1 <= SLEEP_ACTIVE;
			sleep_q <= sleep_s1;
			rdy_s1 <= BROWNOUT_CIRCUIT_ACTIVE;
			rdy_q <= rdy_s1;
		end
	end

	// ------------------------------------------------------------
	// Brown-out control register
	// ------------------------------------------------------------
	logic sw_brownout_enable_q;
	logic brownout_fast_start_q;

	// Both bits always stored, whatever the mode
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			sw_brownout_enable_q <= CTL_RESET[BIT_SW_EN];
			brownout_fast_start_q <= CTL_RESET[BIT_FAST];
		end else if (wr_lane0 && wr_sel == SEL_BORCTL) begin
			sw_brownout_enable_q <= wr.data[BIT_SW_EN];
			brownout_fast_start_q <= wr.data[BIT_FAST];
		end
	end

	// ------------------------------------------------------------
	// Brown-out and band-gap outputs
	// ------------------------------------------------------------
	logic bor_en_q;
	logic bandgap_q;

	// Registered so the analog controls never glitch
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			bor_en_q <= 1'b0;
		end else begin
			unique case (mode_q)
				MODE_SW: bor_en_q <= sw_brownout_enable_q;
				MODE_ON: bor_en_q <= 1'b1;
				MODE_NOSLEEP: bor_en_q <= !sleep_q;
				MODE_OFF: bor_en_q <= 1'b0;
			endcase
		end
	end

	// Fast start only counts in the two modes that may drop the gap
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			bandgap_q <= 1'b0;
		end else if (mode_q == MODE_SW || mode_q == MODE_NOSLEEP) begin
			bandgap_q <= brownout_fast_start_q;
		end else begin
			bandgap_q <= 1'b0;
		end
	end

	assign BROWNOUT_RESET_ENABLE = bor_en_q;
	assign BANDGAP_FORCE_ON = bandgap_q;

	// ------------------------------------------------------------
	// Reset-cause flags
	// ------------------------------------------------------------
	logic [7:0] flags_q;
	logic [7:0] flags_d;
	logic [7:0] ev; // Events as a bit vector

	assign ev = CAUSE_EVENTS;

	// Firmware write first, then hardware events win on top
	always_comb begin
		flags_d = flags_q;
		if (wr_lane0 && wr_sel == SEL_FLAGS) begin
			flags_d = wr.data[7:0];
		end
		if (ev[7]) begin
			flags_d[7] = 1'b1;
		end
		if (ev[6]) begin
			flags_d[6] = 1'b1;
		end
		if (ev[5]) begin
			flags_d[5] = 1'b0;
		end
		if (ev[4]) begin
			flags_d[4] = 1'b0;
		end
		if (ev[3]) begin
			flags_d[3] = 1'b0;
		end
		if (ev[2]) begin
			flags_d[2] = 1'b0;
		end
		if (ev[1]) begin
			flags_d[1] = 1'b0;
		end
		if (ev[0]) begin
			flags_d[0] = 1'b0;
		end
	end

	// Cleared power-on and brown-out bits at start-up
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			flags_q <= FLAGS_RESET;
		end else begin
			flags_q <= flags_d;
		end
	end

	// ------------------------------------------------------------
	// Event status, mask and interrupt
	// ------------------------------------------------------------
	logic [7:0] evstat_q; // Sticky, write one to clear
	logic [7:0] evmask_q; // One lets the event through
	logic irq_q;

	// A new event in the clearing cycle stays set
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			evstat_q <= ZERO8;
		end else if (wr_lane0 && wr_sel == SEL_EVSTAT) begin
			evstat_q <= (evstat_q & ~wr.data[7:0]) | ev;
		end else begin
			evstat_q <= evstat_q | ev;
		end
	end

	// Mask register
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			evmask_q <= MASK_RESET;
		end else if (wr_lane0 && wr_sel == SEL_EVMASK) begin
			evmask_q <= wr.data[7:0];
		end
	end

	// Level interrupt, one cycle behind the status
	always_ff @(posedge SYS_CLK) begin
		if (SYS_RST) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(evstat_q & evmask_q);
		end
	end

	assign IRQ = irq_q;

	// ------------------------------------------------------------
	// Read multiplexer
	// ------------------------------------------------------------
	// Unused bits read zero; ready bit is live status
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (rd_sel)
			SEL_BORCTL: begin
				rd_data[BIT_SW_EN] = sw_brownout_enable_q;
				rd_data[BIT_FAST] = brownout_fast_start_q;
				rd_data[BIT_RDY] = rdy_q;
			end
			SEL_FLAGS: rd_data[7:0] = flags_q;
			SEL_EVSTAT: rd_data[7:0] = evstat_q;
			SEL_EVMASK: rd_data[7:0] = evmask_q;
			SEL_NONE: rd_data = 32'h0000_0000;
		endcase
	end

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK);
	endclocking
	default disable iff (SYS_RST);

	a_sw_mode_enable: assert property (
		mode_q == MODE_SW && $stable(mode_q) |=>
		BROWNOUT_RESET_ENABLE == $past(sw_brownout_enable_q))
		else $error("enable does not follow software bit");

	a_hw_mode_enable: assert property (
		mode_q != MODE_SW && $stable(mode_q) |=>
		BROWNOUT_RESET_ENABLE == ($past(mode_q) == MODE_ON ||
		($past(mode_q) == MODE_NOSLEEP && !$past(sleep_q))))
		else $error("enable wrong in hardware mode");

	a_bandgap_forced: assert property (
		(mode_q == MODE_SW || mode_q == MODE_NOSLEEP) &&
		brownout_fast_start_q |=> BANDGAP_FORCE_ON)
		else $error("band gap not forced on");

	a_bandgap_ignored: assert property (
		(mode_q == MODE_ON || mode_q == MODE_OFF) |=> !BANDGAP_FORCE_ON)
		else $error("fast start acted in fixed mode");

	a_ready_readback: assert property (
		S_AXI_ARVALID && S_AXI_ARREADY && rd_sel == SEL_BORCTL |=>
		S_AXI_RVALID && S_AXI_RDATA[BIT_RDY] == $past(rdy_q))
		else $error("ready bit read wrong");

	a_ovf_set: assert property (ev[7] |=> flags_q[7])
		else $error("overflow flag not set");

	a_unf_set: assert property (ev[6] |=> flags_q[6])
		else $error("underflow flag not set");

	a_window_clear: assert property (ev[5] |=> !flags_q[5])
		else $error("window flag not cleared");

	a_timeout_clear: assert property (ev[4] |=> !flags_q[4])
		else $error("timeout flag not cleared");

	a_pin_clear: assert property (ev[3] |=> !flags_q[3])
		else $error("pin reset flag not cleared");

	a_instr_clear: assert property (ev[2] |=> !flags_q[2])
		else $error("instruction flag not cleared");

	a_por_clear: assert property (ev[1] |=> !flags_q[1])
		else $error("power-on flag not cleared");

	a_bor_clear: assert property (ev[0] |=> !flags_q[0])
		else $error("brown-out flag not cleared");

	a_flags_hold: assert property (
		ev == ZERO8 && !(wr_lane0 && wr_sel == SEL_FLAGS) |=> $stable(flags_q))
		else $error("flag changed with no cause");

	// Checks both edges: raised with an unmasked bit, dropped once none is left
	a_irq_follow: assert property (
		1'b1 |=> IRQ == $past(|(evstat_q & evmask_q)))
		else $error("interrupt does not follow status");

	c_flag_write: cover property (wr_lane0 && wr_sel == SEL_FLAGS);
	c_por_event: cover property (ev[1] ##1 !flags_q[1]);
	c_irq_raise: cover property (!IRQ ##1 IRQ);
	c_bad_read: cover property (S_AXI_RVALID && S_AXI_RRESP == RESP_SLVERR);

endmodule
`default_nettype wire

// >>> rtl/rstcause_pkg.sv
package rstcause_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 8; // Byte address width
	localparam logic [7:0] OFF_BORCTL = 8'h00; // brownout_control
	localparam logic [7:0] OFF_FLAGS = 8'h04; // reset_cause_flags
	localparam logic [7:0] OFF_EVSTAT = 8'h08; // Sticky event status
	localparam logic [7:0] OFF_EVMASK = 8'h0C; // Event interrupt mask

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int BIT_SW_EN = 7; // sw_brownout_enable
	localparam int BIT_FAST = 6; // brownout_fast_start
	localparam int BIT_RDY = 0; // brownout_circuit_ready
	localparam logic [7:0] CTL_RESET = 8'h80; // Enable 1, fast start 0
	localparam logic [7:0] FLAGS_RESET = 8'h3C; // State after power-up
	localparam logic [7:0] MASK_RESET = 8'h00; // All events masked
	localparam logic [7:0] ZERO8 = 8'h00;

	// ------------------------------------------------------------
	// Configuration word brown-out modes
	// ------------------------------------------------------------
	localparam logic [1:0] MODE_OFF = 2'h0; // Always off
	localparam logic [1:0] MODE_SW = 2'h1; // Software controlled
	localparam logic [1:0] MODE_NOSLEEP = 2'h2; // Off in sleep
	localparam logic [1:0] MODE_ON = 2'h3; // Always on

	// ------------------------------------------------------------
	// Bus answers
	// ------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Register selector from decoded address
	typedef enum logic [2:0] {
		SEL_BORCTL = 3'b000,
		SEL_FLAGS = 3'b001,
		SEL_EVSTAT = 3'b010,
		SEL_EVMASK = 3'b011,
		SEL_NONE = 3'b100
	} reg_sel_t;

	// Reset-cause events, ordered as the flag bits 7..0
	typedef struct packed {
		logic stack_overflow;
		logic stack_underflow;
		logic wdt_window_violation;
		logic wdt_timeout;
		logic ext_pin_reset;
		logic reset_instr;
		logic power_on;
		logic brownout;
	} cause_events_t;

	// One register write as handed from the bus slave
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} reg_wr_t;

endpackage

// >>> rtl/axil_reg_slave.sv
`timescale 1ns/10ps
`default_nettype none
// AXI4-Lite slave front end: takes address and data in either order,
// issues one write pulse, and registers read data from the owner.
module axil_reg_slave
	import rstcause_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	output logic wr_en,
	output reg_wr_t wr,
	input wire logic wr_err,
	output logic [ADDR_W-1:0] rd_addr,
	input wire logic [31:0] rd_data,
	input wire logic rd_err
);

	// ------------------------------------------------------------
	// Write path
	// ------------------------------------------------------------
	logic aw_q; // Address held
	logic w_q; // Data held
	logic bvalid_q;
	logic [1:0] bresp_q;
	reg_wr_t wr_q; // Captured address, data and strobes

	// One write at a time: nothing is taken while a response waits
	assign awready = !aw_q && !bvalid_q;
	assign wready = !w_q && !bvalid_q;
	assign wr_en = aw_q && w_q;
	assign wr = wr_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;

	// Capture address and data, each on its own handshake
	always_ff @(posedge clk) begin
		if (rst) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			wr_q <= '0;
		end else begin
			if (awvalid && awready) begin
				aw_q <= 1'b1;
				wr_q.addr <= awaddr;
			end else if (wr_en) begin
				aw_q <= 1'b0;
			end
			if (wvalid && wready) begin
				w_q <= 1'b1;
				wr_q.data <= wdata;
				wr_q.strb <= wstrb;
			end else if (wr_en) begin
				w_q <= 1'b0;
			end
		end
	end

	// Response follows the write pulse by one edge
	always_ff @(posedge clk) begin
		if (rst) begin
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
		end else if (wr_en) begin
			bvalid_q <= 1'b1;
			bresp_q <= wr_err ? RESP_SLVERR : RESP_OKAY;
		end else if (bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Read path
	// ------------------------------------------------------------
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;

	assign arready = !rvalid_q;
	assign rd_addr = araddr;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;

	// Data is sampled in the edge that takes the address
	always_ff @(posedge clk) begin
		if (rst) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_data;
			rresp_q <= rd_err ? RESP_SLVERR : RESP_OKAY;
		end else if (rready) begin
			rvalid_q <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import rstcause_pkg::*;
	// ----------------------------------------
	// Stimulus and observed signals
	// ----------------------------------------
	logic clk = 1'b0; // Bench clock, 8 ns
	logic rst = 1'b1; // Held for 20 cycles
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic [3:0] wstrb = 4'hF; // Byte lanes; only the low lane carries a register
	logic bready = 1'b1, rready = 1'b1; // Always ready, answers taken at once
	logic [1:0] mode = 2'h0; // Configuration brown-out mode
	logic sleep = 1'b0, cact = 1'b0;
	cause_events_t ev = '0; // One-cycle cause pulses
	logic awready, wready, bvalid, arready, rvalid, bor_en, bg_on, irq;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata;
	logic [33:0] rq[$]; // Expected read answers
	logic [1:0] bq[$]; // Expected write answers
	int failures = 0, check_count = 0;
	logic [31:0] seed = 32'h0000_0056; // Starts at 86
	logic [31:0] v;
	logic [33:0] e;
	always #4 clk = ~clk;
	reset_cause_and_brownout_control i_reset_cause_and_brownout_control (
		.SYS_CLK(clk), .SYS_RST(rst),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
		.S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
		.S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
		.BROWNOUT_CONFIG_MODE(mode), .SLEEP_ACTIVE(sleep),
		.BROWNOUT_CIRCUIT_ACTIVE(cact), .CAUSE_EVENTS(ev),
		.BROWNOUT_RESET_ENABLE(bor_en), .BANDGAP_FORCE_ON(bg_on), .IRQ(irq)
	);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic finish_test();
		if (failures == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// A wait that runs out is a mismatch and ends the run
	task automatic timeout();
		failures++;
		finish_test();
	endtask
	// Write: address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		int n;
		logic ta, tw;
		bq.push_back(r);
		ta = 1'b0;
		tw = 1'b0;
		n = 0;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ta && tw)) begin
			@(negedge clk);
			if (awvalid && awready) ta = 1'b1;
			if (wvalid && wready) tw = 1'b1;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			n++;
			if (n > 50) timeout();
		end
		n = 0;
		do begin
			@(negedge clk);
			n++;
			if (n > 50) timeout();
		end while (!bvalid);
		@(posedge clk);
	endtask
	// Read: expectation noted first, monitor compares when data shows
	task automatic rd(input logic [7:0] a, input logic [33:0] x);
		int n;
		rq.push_back(x);
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge clk);
			n++;
			if (n > 50) timeout();
		end while (!arready);
		@(posedge clk);
		arvalid <= 1'b0;
		do begin
			@(negedge clk);
			n++;
			if (n > 50) timeout();
		end while (!rvalid);
		@(posedge clk);
	endtask
	task automatic pulse(input int i);
		@(posedge clk);
		ev <= cause_events_t'(8'h01 << i);
		@(posedge clk);
		ev <= '0;
	endtask
	// ----------------------------------------
	// Answer monitor, oldest note first
	// ----------------------------------------
	always @(negedge clk) begin
		if (rvalid && rready) begin
			if (rq.size() == 0) timeout();
			else cmp({rresp, rdata}, rq.pop_front());
		end
		if (bvalid && bready) begin
			if (bq.size() == 0) timeout();
			else cmp({32'h0000_0000, bresp}, {32'h0000_0000, bq.pop_front()});
		end
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		cmp({33'h0, irq}, 34'h0);
		rd(OFF_BORCTL, {RESP_OKAY, 32'h0000_0080});
		rd(OFF_FLAGS, {RESP_OKAY, 32'h0000_003C});
		rd(OFF_EVSTAT, {RESP_OKAY, 32'h0000_0000});
		rd(OFF_EVMASK, {RESP_OKAY, 32'h0000_0000});
		// Unmapped place answers an error and changes nothing
		rd(8'h10, {RESP_SLVERR, 32'h0000_0000});
		wr(8'h10, xs(), RESP_SLVERR);
		// Low lane switched off: write is answered but stores nothing
		wstrb <= 4'h0;
		wr(OFF_FLAGS, 32'h0000_0000, RESP_OKAY);
		wstrb <= 4'hF;
		rd(OFF_FLAGS, {RESP_OKAY, 32'h0000_003C});
		@(posedge clk);
		cact <= 1'b1;
		// Every mode against every enable, fast-start and sleep setting
		for (int m = 0; m < 4; m++) begin
			for (int s = 0; s < 2; s++) begin
				for (int c = 0; c < 4; c++) begin
					@(posedge clk);
					mode <= m[1:0];
					sleep <= s[0];
					wr(OFF_BORCTL, {24'h0, c[1], c[0], 6'h0}, RESP_OKAY);
					// Mode crosses two sync stages, output one edge later
					repeat (5) @(posedge clk);
					@(negedge clk);
					e[1] = (m == 1) ? c[1] : (m == 2) ? !s[0] : (m == 3);
					e[0] = (m == 1 || m == 2) && c[0];
					cmp({32'h0, bor_en, bg_on}, {32'h0, e[1:0]});
					rd(OFF_BORCTL, {RESP_OKAY, 24'h0, c[1], c[0], 6'h01});
				end
			end
		end
		// Each cause touches only its own flag
		for (int i = 0; i < 8; i++) begin
			v = xs();
			wr(OFF_FLAGS, v, RESP_OKAY);
			pulse(i);
			e = {RESP_OKAY, 24'h0, (i >= 6) ? (v[7:0] | (8'h01 << i)) : (v[7:0] & ~(8'h01 << i))};
			rd(OFF_FLAGS, e);
		end
		// Interrupt: raised only when unmasked, dropped by write-one-clear
		rd(OFF_EVSTAT, {RESP_OKAY, 32'h0000_00FF});
		cmp({33'h0, irq}, 34'h0);
		wr(OFF_EVMASK, 32'h0000_0002, RESP_OKAY);
		repeat (2) @(posedge clk);
		@(negedge clk);
		cmp({33'h0, irq}, 34'h1);
		wr(OFF_EVSTAT, 32'h0000_00FD, RESP_OKAY);
		rd(OFF_EVSTAT, {RESP_OKAY, 32'h0000_0002});
		wr(OFF_EVSTAT, 32'h0000_0002, RESP_OKAY);
		repeat (2) @(posedge clk);
		@(negedge clk);
		cmp({33'h0, irq}, 34'h0);
		finish_test();
	end
endmodule
`default_nettype wire
